// ### design/mfi_pkg.sv
// Purpose: Constants and types for the multi-function interrupt flag block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
package mfi_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [3:0] MFI_HALL_OFS  = 4'h0;
    localparam logic [3:0] MFI_CAPAD_OFS = 4'h4;
    localparam logic [7:0] MFI_RST_VAL   = 8'h00;
    // Hall register layout: flags in the upper nibble, enables below
    localparam logic [7:0] MFI_HALL_MASK = 8'h77;
    localparam int         MFI_FLAG_LSB  = 4;
    localparam int         MFI_NUM_SRC   = 4;
    // Bus response codes
    localparam logic [1:0] MFI_RESP_OKAY   = 2'h0;
    localparam logic [1:0] MFI_RESP_SLVERR = 2'h2;

    // Event pulses from the peripherals
    typedef struct packed {
        logic hall_c_event;
        logic hall_b_event;
        logic hall_a_event;
    } mfi_hall_ev_t;

    typedef struct packed {
        logic cap_compare;
        logic cap_overflow;
        logic adc_compare;
        logic adc_done;
    } mfi_capad_ev_t;
endpackage

// ### design/mfi_irq_flags.sv
// Purpose: Hall and capture/ADC multi-function interrupt flag registers
// Assumes: Event pulses are synchronous to clk, one cycle each
// Notes:   Upper nibble holds flags, lower nibble the matching enables
`timescale 1ns/100ps
module mfi_irq_flags
    import mfi_pkg::*;
(
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          nrst,
    // Peripheral events
    input  wire mfi_hall_ev_t  hall_ev,
    input  wire mfi_capad_ev_t capad_ev,
    // Requests to CPU interrupt logic
    output logic               hall_irq_req,
    output logic               capad_irq_req,
    // AXI4-Lite write address
    input  wire logic [31:0]   s_axi_awaddr,
    input  wire logic          s_axi_awvalid,
    output logic               s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]   s_axi_wdata,
    input  wire logic [3:0]    s_axi_wstrb,
    input  wire logic          s_axi_wvalid,
    output logic               s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]         s_axi_bresp,
    output logic               s_axi_bvalid,
    input  wire logic          s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0]   s_axi_araddr,
    input  wire logic          s_axi_arvalid,
    output logic               s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]        s_axi_rdata,
    output logic [1:0]         s_axi_rresp,
    output logic               s_axi_rvalid,
    input  wire logic          s_axi_rready
);
    // ------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------
    logic [3:0]  aw_addr_r;
    logic        aw_have_r;
    logic [7:0]  w_data_r;
    logic        w_byte_r;
    logic        w_have_r;
    logic [7:0]  hall_r;
    logic [7:0]  capad_r;

    // Address and data are taken independently, response after both
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_fire  = aw_have_r && w_have_r && !s_axi_bvalid;
    wire wr_hall  = wr_fire && w_byte_r && (aw_addr_r == MFI_HALL_OFS);
    wire wr_capad = wr_fire && w_byte_r && (aw_addr_r == MFI_CAPAD_OFS);
    wire wr_known = (aw_addr_r == MFI_HALL_OFS) || (aw_addr_r == MFI_CAPAD_OFS);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            aw_have_r <= 1'b0;
            aw_addr_r <= 4'h0;
        end else if (aw_take) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= (s_axi_awaddr[31:4] == 28'h0000000) ? s_axi_awaddr[3:0] : 4'hF;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            w_have_r <= 1'b0;
            w_data_r <= 8'h00;
            w_byte_r <= 1'b0;
        end else if (w_take) begin
            w_have_r <= 1'b1;
            w_data_r <= s_axi_wdata[7:0];
            w_byte_r <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end

    // Ready while the holding slot is free and no write response is pending
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !aw_take && !s_axi_bvalid;
            s_axi_wready  <= !w_have_r && !w_take && !s_axi_bvalid;
        end
    end

    // Write response, error for an unmapped word
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= MFI_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_known ? MFI_RESP_OKAY : MFI_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Flag and enable registers
    // ------------------------------------------------------------
    logic [7:0] hall_nxt;
    logic [7:0] capad_nxt;
    wire  [7:0] hall_set  = {1'b0, hall_ev.hall_c_event, hall_ev.hall_b_event,
                             hall_ev.hall_a_event, 4'h0};
    wire  [7:0] capad_set = {capad_ev.cap_compare, capad_ev.cap_overflow,
                             capad_ev.adc_compare, capad_ev.adc_done, 4'h0};

    // Write stores, then events set; a set wins over a clearing write
    assign hall_nxt  = ((wr_hall ? w_data_r : hall_r) | hall_set) & MFI_HALL_MASK;
    assign capad_nxt = (wr_capad ? w_data_r : capad_r) | capad_set;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hall_r  <= MFI_RST_VAL;
            capad_r <= MFI_RST_VAL;
        end else begin
            hall_r  <= hall_nxt;
            capad_r <= capad_nxt;
        end
    end

    // ------------------------------------------------------------
    // Combined requests
    // ------------------------------------------------------------
    wire [MFI_NUM_SRC-1:0] hall_act  = hall_nxt[MFI_FLAG_LSB +: MFI_NUM_SRC] & hall_nxt[MFI_NUM_SRC-1:0];
    wire [MFI_NUM_SRC-1:0] capad_act = capad_nxt[MFI_FLAG_LSB +: MFI_NUM_SRC] & capad_nxt[MFI_NUM_SRC-1:0];

    // Registered so the request follows the register contents exactly
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hall_irq_req  <= 1'b0;
            capad_irq_req <= 1'b0;
        end else begin
            hall_irq_req  <= |hall_act;
            capad_irq_req <= |capad_act;
        end
    end

    // ------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------
    wire        ar_take = s_axi_arvalid && s_axi_arready;
    wire        rd_hi   = s_axi_araddr[31:4] != 28'h0000000;
    wire        rd_hall = !rd_hi && (s_axi_araddr[3:0] == MFI_HALL_OFS);
    wire        rd_cap  = !rd_hi && (s_axi_araddr[3:0] == MFI_CAPAD_OFS);
    wire [7:0]  rd_byte = rd_hall ? hall_r : (rd_cap ? capad_r : 8'h00);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= MFI_RESP_OKAY;
        end else if (ar_take) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h000000, rd_byte};
            s_axi_rresp   <= (rd_hall || rd_cap) ? MFI_RESP_OKAY : MFI_RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            s_axi_rvalid  <= !s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence seq_hall_c;
        hall_ev.hall_c_event;
    endsequence

    AST_HALL_SET: assert property (@(posedge clk) disable iff (!nrst)
        seq_hall_c |=> hall_r[6])
        else $error("hall C flag not set after event");

    AST_HALL_UNUSED: assert property (@(posedge clk) disable iff (!nrst)
        (hall_r[7] == 1'b0) && (hall_r[3] == 1'b0))
        else $error("unimplemented hall bit set");

    AST_HALL_EN: assert property (@(posedge clk) disable iff (!nrst)
        wr_hall && !hall_set[6] |=> hall_r[2:0] == $past(w_data_r[2:0]))
        else $error("hall enables not written");

    AST_CAP_CMP: assert property (@(posedge clk) disable iff (!nrst)
        capad_ev.cap_compare |=> capad_r[7])
        else $error("compare flag not set");

    AST_CAP_OVF: assert property (@(posedge clk) disable iff (!nrst)
        capad_ev.cap_overflow |=> capad_r[6])
        else $error("overflow flag not set");

    AST_ADC_CMP: assert property (@(posedge clk) disable iff (!nrst)
        capad_ev.adc_compare |=> capad_r[5])
        else $error("adc compare flag not set");

    AST_ADC_DONE: assert property (@(posedge clk) disable iff (!nrst)
        capad_ev.adc_done |=> capad_r[4])
        else $error("adc done flag not set");

    AST_FLAG_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !wr_capad && capad_r[7] |=> capad_r[7])
        else $error("flag cleared without write");

    AST_FLAG_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        wr_hall && !w_data_r[4] && !hall_ev.hall_a_event |=> !hall_r[4])
        else $error("zero write did not clear flag");

    AST_REQ: assert property (@(posedge clk) disable iff (!nrst)
        hall_irq_req == |(hall_r[6:4] & hall_r[2:0]))
        else $error("hall request mismatch");

    AST_REQ_CAP: assert property (@(posedge clk) disable iff (!nrst)
        ##1 capad_irq_req == |(capad_r[7:4] & capad_r[3:0]))
        else $error("capture request mismatch");

    // Hall A and B flags follow their events as C does
    AST_HALL_B_SET: assert property (@(posedge clk) disable iff (!nrst)
        hall_ev.hall_b_event |=> hall_r[5])
        else $error("hall B flag not set after event");

    AST_HALL_A_SET: assert property (@(posedge clk) disable iff (!nrst)
        hall_ev.hall_a_event |=> hall_r[4])
        else $error("hall A flag not set after event");

    // Enables of the capture/ADC register take the written nibble
    AST_CAP_EN: assert property (@(posedge clk) disable iff (!nrst)
        wr_capad |=> capad_r[3:0] == $past(w_data_r[3:0]))
        else $error("capture/ADC enables not written");

    // Flags stay put between software writes
    AST_HALL_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        !wr_hall && hall_r[6] |=> hall_r[6])
        else $error("hall flag cleared without write");

    AST_CAP_CLEAR: assert property (@(posedge clk) disable iff (!nrst)
        wr_capad && !w_data_r[7] && !capad_ev.cap_compare |=> !capad_r[7])
        else $error("zero write did not clear compare flag");

    // A clearing write and a new event in one cycle: the event wins
    sequence seq_hall_a_clash;
        wr_hall && !w_data_r[4] && hall_ev.hall_a_event;
    endsequence

    AST_SET_WINS: assert property (@(posedge clk) disable iff (!nrst)
        seq_hall_a_clash |=> hall_r[4])
        else $error("clearing write hid a new event");

    // ------------------------------------------------------------
    // Bus handshake checks
    // ------------------------------------------------------------
    // Both halves of a write held and no response pending
    sequence seq_wr_both;
        aw_have_r && w_have_r && !s_axi_bvalid;
    endsequence

    // Response offered and not yet accepted
    sequence seq_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence

    // Read data offered and not yet accepted
    sequence seq_r_wait;
        s_axi_rvalid && !s_axi_rready;
    endsequence

    AST_WR_RESP: assert property (@(posedge clk) disable iff (!nrst)
        seq_wr_both |=> s_axi_bvalid)
        else $error("write response missing");

    AST_B_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        seq_b_wait |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before accept");

    AST_AW_BUSY: assert property (@(posedge clk) disable iff (!nrst)
        s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write ready while response pending");

    AST_R_ANSWER: assert property (@(posedge clk) disable iff (!nrst)
        ar_take |=> s_axi_rvalid)
        else $error("read data missing");

    AST_R_HOLD: assert property (@(posedge clk) disable iff (!nrst)
        seq_r_wait |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
        else $error("read data dropped before accept");

    AST_AR_BUSY: assert property (@(posedge clk) disable iff (!nrst)
        s_axi_rvalid |-> !s_axi_arready)
        else $error("read ready while data pending");

    // Only the low byte carries register bits
    AST_R_UPPER: assert property (@(posedge clk) disable iff (!nrst)
        s_axi_rdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");
endmodule

// ### verification/mfi_event_model.sv
// Purpose: Peripheral event source model for the interrupt flag block
// Assumes: Each event is a one-cycle pulse launched right after a rising edge
// Notes:   Source 0..2 is hall A..C, 3..6 is ADC done, ADC compare, overflow, compare match
`timescale 1ns/100ps
module mfi_event_model
    import mfi_pkg::*;
(
    // Clock
    input  wire logic clk,
    // Event pulses
    output mfi_hall_ev_t  hall_ev,
    output mfi_capad_ev_t capad_ev
);
    // Quiet until asked
    initial begin
        hall_ev  = '0;
        capad_ev = '0;
    end
    // One-cycle pulse on the chosen source, then quiet again
    task automatic fire(input int src);
        @(posedge clk);
        if (src < 3) hall_ev <= mfi_hall_ev_t'(3'h1 << src);
        else capad_ev <= mfi_capad_ev_t'(4'h1 << (src - 3));
        @(posedge clk);
        hall_ev  <= '0;
        capad_ev <= '0;
    endtask
endmodule

// ### verification/multifunction_irq_flags_hall_cap_adc_bench.sv
// Purpose: Self-checking bench for the interrupt flag registers
// Assumes: Bus handshakes are judged at the rising edge that takes them
// Notes:   Every source is walked through set, enable, hold and clear
`timescale 1ns/100ps
module multifunction_irq_flags_hall_cap_adc_bench
    import mfi_pkg::*;
;
    logic          clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic          arvalid, arready, rvalid, rready, hall_irq_req, capad_irq_req;
    logic [31:0]   awaddr, wdata, araddr, rdata, d;
    logic [3:0]    wstrb;
    logic [1:0]    bresp, rresp, r;
    mfi_hall_ev_t  hall_ev;
    mfi_capad_ev_t capad_ev;
    int            n_errors, comparisons;
    logic [31:0]   a, m, e;
    // ------------------------------------------------------------
    // Clock, design and event source
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    mfi_irq_flags dut (.clk(clk), .nrst(nrst), .hall_ev(hall_ev), .capad_ev(capad_ev),
        .hall_irq_req(hall_irq_req), .capad_irq_req(capad_irq_req), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    mfi_event_model ev (.clk(clk), .hall_ev(hall_ev), .capad_ev(capad_ev));
    // ------------------------------------------------------------
    // Bus tasks and comparisons
    // ------------------------------------------------------------
    task automatic axi_write(input logic [31:0] ad, input logic [31:0] dt, input logic [3:0] st);
        logic bh;
        int   t;
        @(posedge clk);
        awaddr <= ad; wdata <= dt; wstrb <= st; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        bh = 1'b0;
        t = 0;
        // Each channel is released at the rising edge that takes it
        while (!bh && t < 100) begin
            @(posedge clk);
            t++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                bh = 1'b1;
                r = bresp;
                bready <= 1'b0;
            end
        end
        if (!bh) begin
            n_errors++;
            $display("unexpected write timeout at %0t: got %h expected %h", $time, bh, 1'b1);
        end
    endtask
    task automatic axi_read(input logic [31:0] ad);
        logic rh;
        int   t;
        @(posedge clk);
        araddr <= ad; arvalid <= 1'b1; rready <= 1'b1;
        rh = 1'b0;
        t = 0;
        // Data and response are taken at the edge that accepts them
        while (!rh && t < 100) begin
            @(posedge clk);
            t++;
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rh = 1'b1;
                d = rdata;
                r = rresp;
                rready <= 1'b0;
            end
        end
        if (!rh) begin
            n_errors++;
            $display("unexpected read timeout at %0t: got %h expected %h", $time, rh, 1'b1);
        end
    endtask
    task automatic cmp_data(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected data at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic cmp_resp(input logic [1:0] g, input logic [1:0] x);
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected response at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    // Request line of a source, looked at where it is settled
    task automatic cmp_req(input int s, input logic x);
        logic g;
        @(negedge clk);
        g = (s < 3) ? hall_irq_req : capad_irq_req;
        comparisons++;
        if (g !== x) begin
            n_errors++;
            $display("unexpected request at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task automatic results();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Watchdog cuts a hang short
    initial begin
        #100000;
        n_errors++;
        results();
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        nrst = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
        awaddr = '0; wdata = '0; wstrb = '0; araddr = '0; n_errors = 0; comparisons = 0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        axi_read({28'h0, MFI_HALL_OFS});
        cmp_data(d, 32'h00);
        axi_read({28'h0, MFI_CAPAD_OFS});
        cmp_data(d, 32'h00);
        axi_write({28'h0, MFI_HALL_OFS}, 32'hFF, 4'hF);
        axi_read({28'h0, MFI_HALL_OFS});
        cmp_data(d, 32'h77);
        cmp_req(0, 1'b1);
        // Each source: other enables only, then own enable, hold, clear
        for (int s = 0; s < 7; s++) begin
            a = (s < 3) ? {28'h0, MFI_HALL_OFS} : {28'h0, MFI_CAPAD_OFS};
            m = (32'h1 << ((s < 3) ? s : s - 3));
            e = ((s < 3) ? 32'h07 : 32'h0F) & ~m;
            axi_write(a, 32'h0F & ~m, 4'hF);
            ev.fire(s);
            cmp_req(s, 1'b0);
            axi_read(a);
            cmp_data(d, e | (m << 4));
            axi_write(a, d | m, 4'hF);
            cmp_req(s, 1'b1);
            repeat (20) @(posedge clk);
            cmp_req(s, 1'b1);
            axi_write(a, m, 4'hF);
            cmp_req(s, 1'b0);
            axi_read(a);
            cmp_data(d, m);
        end
        // Unmapped word and a write with no byte lane
        axi_write(32'h8, 32'hFF, 4'hF);
        cmp_resp(r, MFI_RESP_SLVERR);
        axi_read(32'h8);
        cmp_resp(r, MFI_RESP_SLVERR);
        cmp_data(d, 32'h0);
        axi_write({28'h0, MFI_CAPAD_OFS}, 32'hFF, 4'h0);
        cmp_resp(r, MFI_RESP_OKAY);
        axi_read({28'h0, MFI_CAPAD_OFS});
        cmp_data(d, 32'h08);
        // A clearing write meets a hall A event at its commit edge: the event wins
        fork
            axi_write({28'h0, MFI_HALL_OFS}, 32'h00, 4'hF);
            begin
                @(posedge clk);
                ev.fire(0);
            end
        join
        axi_read({28'h0, MFI_HALL_OFS});
        cmp_data(d, 32'h10);
        results();
    end
endmodule
